// *** cpd_clock_prescale_and_drive_gate.sv ***
// Purpose: Clock prescalers, driver enable gate and driver fault status
// Assumes: Analog flags and the drive-enable pin are asynchronous
// Notes:   Register port runs on the undivided system clock
`timescale 1ns/1ps

module cpd_clock_prescale_and_drive_gate (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register access port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [9:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic [15:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  // Configuration levels
  input  wire logic        i_clk_loss_cut_en,
  input  wire logic        i_low_side7_pin_bypass,
  input  wire logic        i_boost_cut_en,
  input  wire logic        i_status_read_clear_en,
  // Pins and analog flags
  input  wire logic        i_drive_enable_pin,
  input  wire logic        i_predrive_supply_low,
  input  wire logic        i_logic_supply_low,
  input  wire logic        i_boost_supply_low,
  input  wire logic        i_ground_loss,
  input  wire logic        i_over_temp,
  input  wire logic        i_clock_missing,
  // Driver enables
  output logic             o_low_side_enable,
  output logic             o_low_side7_enable,
  output logic             o_high_side_enable,
  // Divided clocks
  output logic             o_core_clock,
  output logic             o_core_tick,
  output logic             o_offset_comp_clock,
  output logic             o_offset_comp_tick,
  // Operating mode permissions
  output logic             o_single_core_allowed,
  output logic             o_dual_core_allowed,
  output logic             o_flag_drive_allowed
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [6:0] sync_1_reg;
  logic [6:0] sync_2_reg;
  logic [6:0] sync_raw;

  // Gather the asynchronous inputs
  always_comb begin
    sync_raw = cpd_pkg::CPD_SYNC_RESET;
    sync_raw[cpd_pkg::CPD_IN_PIN]         = i_drive_enable_pin;
    sync_raw[cpd_pkg::CPD_IN_PREDRIVE]    = i_predrive_supply_low;
    sync_raw[cpd_pkg::CPD_IN_LOGIC]       = i_logic_supply_low;
    sync_raw[cpd_pkg::CPD_IN_BOOST]       = i_boost_supply_low;
    sync_raw[cpd_pkg::CPD_IN_GND_LOSS]    = i_ground_loss;
    sync_raw[cpd_pkg::CPD_IN_OVER_TEMP]   = i_over_temp;
    sync_raw[cpd_pkg::CPD_IN_CLK_MISSING] = i_clock_missing;
  end

  // Two-stage synchroniser; only sync_2_reg is read below
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_1_reg <= cpd_pkg::CPD_SYNC_RESET;
      sync_2_reg <= cpd_pkg::CPD_SYNC_RESET;
    end else begin
      sync_1_reg <= sync_raw;
      sync_2_reg <= sync_1_reg;
    end
  end

  logic pin_s;
  logic predrive_fault_s;
  logic logic_low_s;
  logic boost_low_s;
  logic over_temp_s;
  logic clk_missing_s;

  // Synchronised views; ground loss counts as a predrive fault
  assign pin_s            = sync_2_reg[cpd_pkg::CPD_IN_PIN];
  assign predrive_fault_s = sync_2_reg[cpd_pkg::CPD_IN_PREDRIVE]
                          | sync_2_reg[cpd_pkg::CPD_IN_GND_LOSS];   // R16
  assign logic_low_s      = sync_2_reg[cpd_pkg::CPD_IN_LOGIC];
  assign boost_low_s      = sync_2_reg[cpd_pkg::CPD_IN_BOOST];
  assign over_temp_s      = sync_2_reg[cpd_pkg::CPD_IN_OVER_TEMP];
  assign clk_missing_s    = sync_2_reg[cpd_pkg::CPD_IN_CLK_MISSING];

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic wr_core_div;
  logic wr_ofs_div;
  logic wr_status;
  logic rd_status;

  // Strobe decode on the system clock
  assign wr_core_div = i_reg_wr && (i_reg_addr == cpd_pkg::CPD_CORE_DIV_ADDR); // R1 R3
  assign wr_ofs_div  = i_reg_wr && (i_reg_addr == cpd_pkg::CPD_OFS_DIV_ADDR);  // R1 R3
  assign wr_status   = i_reg_wr && (i_reg_addr == cpd_pkg::CPD_STATUS_ADDR);
  assign rd_status   = i_reg_rd && (i_reg_addr == cpd_pkg::CPD_STATUS_ADDR);

  // ---------------------------------------------------------------
  // Divider registers
  // ---------------------------------------------------------------
  logic [5:0] core_div_reg;
  logic [5:0] core_div_next;
  logic [7:0] ofs_div_reg;
  logic [7:0] ofs_div_next;

  // Field updates; reserved bits are not stored
  always_comb begin
    core_div_next = core_div_reg;
    ofs_div_next  = ofs_div_reg;
    if (wr_core_div) begin
      core_div_next = i_reg_wdata[5:0];  // R1
    end
    if (wr_ofs_div) begin
      ofs_div_next = i_reg_wdata[7:0];   // R1
    end
  end

  // Register divider fields
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      core_div_reg <= cpd_pkg::CPD_CORE_DIV_RESET;
      ofs_div_reg  <= cpd_pkg::CPD_OFS_DIV_RESET;
    end else begin
      core_div_reg <= core_div_next;
      ofs_div_reg  <= ofs_div_next;
    end
  end

  // ---------------------------------------------------------------
  // Prescalers
  // ---------------------------------------------------------------
  // Core execution clock, system clock over field+1
  cpd_clock_divider #(
    .W       (cpd_pkg::CPD_CORE_DIV_W)
  ) u_core_div (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ratio (core_div_reg),           // R2
    .o_tick  (o_core_tick),
    .o_clk   (o_core_clock)
  );

  // Offset compensation clock for the recovery counters
  cpd_clock_divider #(
    .W       (cpd_pkg::CPD_OFS_DIV_W)
  ) u_ofs_div (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ratio (ofs_div_reg),            // R5
    .o_tick  (o_offset_comp_tick),
    .o_clk   (o_offset_comp_clock)
  );

  // ---------------------------------------------------------------
  // Mode permissions and driver enables
  // ---------------------------------------------------------------
  logic mode_single_reg;
  logic mode_single_next;
  logic mode_dual_reg;
  logic mode_dual_next;
  logic clock_ok_gate;
  logic ls_ok;
  logic ls_en_reg;
  logic ls_en_next;
  logic ls7_en_reg;
  logic ls7_en_next;
  logic hs_en_reg;
  logic hs_en_next;

  // Mode gates from the core divider field
  always_comb begin
    mode_single_next = (core_div_reg >= cpd_pkg::CPD_SINGLE_CORE_MIN); // R4
    mode_dual_next   = (core_div_reg >= cpd_pkg::CPD_DUAL_CORE_MIN);   // R4
  end

  // Enable combination, evaluated every system clock
  always_comb begin
    clock_ok_gate = ~(i_clk_loss_cut_en & clk_missing_s);              // R19
    ls_ok         = clock_ok_gate & ~predrive_fault_s & ~logic_low_s;
    ls_en_next    = ls_ok & pin_s;                                     // R7 R21
    ls7_en_next   = ls_ok & (pin_s | i_low_side7_pin_bypass);          // R8 R20
    hs_en_next    = ls_en_next & ~(i_boost_cut_en & boost_low_s);      // R9
  end

  // Register enables and mode gates
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_single_reg <= 1'b0;
      mode_dual_reg   <= 1'b0;
      ls_en_reg       <= 1'b0;
      ls7_en_reg      <= 1'b0;
      hs_en_reg       <= 1'b0;
    end else begin
      mode_single_reg <= mode_single_next;
      mode_dual_reg   <= mode_dual_next;
      ls_en_reg       <= ls_en_next;
      ls7_en_reg      <= ls7_en_next;
      hs_en_reg       <= hs_en_next;
    end
  end

  // Separate side enables
  assign o_low_side_enable     = ls_en_reg;   // R6
  assign o_low_side7_enable    = ls7_en_reg;
  assign o_high_side_enable    = hs_en_reg;   // R6
  assign o_single_core_allowed = mode_single_reg;
  assign o_flag_drive_allowed  = mode_single_reg;
  assign o_dual_core_allowed   = mode_dual_reg;

  // ---------------------------------------------------------------
  // Driver fault status
  // ---------------------------------------------------------------
  logic [6:0] status_reg;
  logic [6:0] status_next;
  logic       status_clr;
  logic       clk_cut_set;
  logic       boost_cut_set;

  // Clear on write, or on read when enabled
  assign status_clr    = wr_status | (rd_status & i_status_read_clear_en); // R17 R18
  assign clk_cut_set   = i_clk_loss_cut_en & clk_missing_s;                // R11
  assign boost_cut_set = i_boost_cut_en & boost_low_s;                     // R15

  // Sticky latches, set wins over clear
  always_comb begin
    status_next = status_reg;
    status_next[cpd_pkg::CPD_ST_PREDRIVE]   = cpd_pkg::cpd_sticky(
      status_reg[cpd_pkg::CPD_ST_PREDRIVE], predrive_fault_s,
      status_clr, predrive_fault_s);                                    // R16 R10
    status_next[cpd_pkg::CPD_ST_LOGIC]      = cpd_pkg::cpd_sticky(
      status_reg[cpd_pkg::CPD_ST_LOGIC], logic_low_s,
      status_clr, logic_low_s);                                         // R16
    status_next[cpd_pkg::CPD_ST_BOOST]      = cpd_pkg::cpd_sticky(
      status_reg[cpd_pkg::CPD_ST_BOOST], boost_cut_set,
      status_clr, boost_cut_set);                                       // R15
    status_next[cpd_pkg::CPD_ST_OVER_TEMP]  = cpd_pkg::cpd_sticky(
      status_reg[cpd_pkg::CPD_ST_OVER_TEMP], over_temp_s,
      status_clr, over_temp_s);                                         // R14
    status_next[cpd_pkg::CPD_ST_CLOCK_LOST] = cpd_pkg::cpd_sticky(
      status_reg[cpd_pkg::CPD_ST_CLOCK_LOST], clk_cut_set,
      status_clr, clk_cut_set);                                         // R11
    status_next[cpd_pkg::CPD_ST_PIN_LEVEL]  = pin_s;                    // R13
    // Falls when pin seen low; a clear re-arms it only while pin is high
    status_next[cpd_pkg::CPD_ST_PIN_NOT_LOW] =
      pin_s & (status_reg[cpd_pkg::CPD_ST_PIN_NOT_LOW] | status_clr);   // R12
  end

  // Register status
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_reg <= cpd_pkg::CPD_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    rdata_next  = 16'h0000;
    rvalid_next = i_reg_rd;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        cpd_pkg::CPD_CORE_DIV_ADDR: rdata_next = {10'h000, core_div_reg};
        cpd_pkg::CPD_OFS_DIV_ADDR:  rdata_next = {8'h00, ofs_div_reg};
        cpd_pkg::CPD_STATUS_ADDR:   rdata_next = {9'h000, status_reg};  // R10
        default:                    rdata_next = 16'h0000;
      endcase
    end
  end

  // Register read answer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_reg_rdata  = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Predrive fault kills every driver next cycle
  supply_cut_a: assert property (predrive_fault_s |=> // R7
    (!o_low_side_enable && !o_low_side7_enable && !o_high_side_enable))
    else $error("drivers enabled under predrive fault");

  // Bypass lets low-side 7 run with pin low
  ls7_bypass_a: assert property ( // R8 R20
    (i_low_side7_pin_bypass && !pin_s && !predrive_fault_s && !logic_low_s
     && !(i_clk_loss_cut_en && clk_missing_s)) |=> o_low_side7_enable)
    else $error("low-side 7 not enabled under bypass");

  // High side never on without low side
  hs_needs_ls_a: assert property (o_high_side_enable |-> o_low_side_enable) // R9
    else $error("high side on while low side off");

  // Boost cut drops high side and latches status
  boost_cut_a: assert property ((i_boost_cut_en && boost_low_s) |=> // R15
    (!o_high_side_enable && status_reg[cpd_pkg::CPD_ST_BOOST]))
    else $error("boost cut not applied");

  // Clock loss gates drivers and latches status
  clock_cut_a: assert property ((i_clk_loss_cut_en && clk_missing_s) |=> // R11 R19
    (!o_low_side_enable && status_reg[cpd_pkg::CPD_ST_CLOCK_LOST]))
    else $error("clock loss cut not applied");

  // Clear refused while cause persists
  clear_hold_a: assert property ((wr_status && logic_low_s) |=> // R17
    status_reg[cpd_pkg::CPD_ST_LOGIC])
    else $error("logic flag cleared while present");

  // Read clear works when enabled and cause gone
  read_clear_a: assert property ( // R18
    (rd_status && i_status_read_clear_en && !predrive_fault_s)
    |=> !status_reg[cpd_pkg::CPD_ST_PREDRIVE])
    else $error("read clear failed");

  // Pin low seen drops the latch, live copy follows
  pin_seen_a: assert property (!pin_s |=> // R12 R13
    (!status_reg[cpd_pkg::CPD_ST_PIN_NOT_LOW] && !status_reg[cpd_pkg::CPD_ST_PIN_LEVEL]))
    else $error("pin low not recorded");

  // Overtemperature latches without cutting drivers
  over_temp_a: assert property ( // R14
    (over_temp_s && pin_s && !predrive_fault_s && !logic_low_s
     && !(i_clk_loss_cut_en && clk_missing_s))
    |=> (status_reg[cpd_pkg::CPD_ST_OVER_TEMP] && o_low_side_enable))
    else $error("overtemperature handling wrong");

  // Divider write lands and dual mode follows
  div_write_a: assert property ((wr_core_div && i_reg_wdata[5:0] == 6'h03) // R1 R4
    |=> (core_div_reg == 6'h03) ##1 (o_dual_core_allowed && o_single_core_allowed))
    else $error("core divider write or mode wrong");

  // Divide by five spacing of core ticks
  core_period_a: assert property ( // R2
    (o_core_tick && core_div_reg == 6'h04 && !wr_core_div) ##1
    (!wr_core_div && !o_core_tick)[*4] |-> ##1 o_core_tick)
    else $error("core tick spacing wrong");

  // Main scenarios
  enables_on_c:  cover property (o_high_side_enable && o_low_side7_enable);
  clear_done_c:  cover property (wr_status ##1 status_reg == cpd_pkg::CPD_STATUS_RESET);
  ofs_tick_c:    cover property (o_offset_comp_tick && ofs_div_reg == 8'h08);
  read_clear_c:  cover property (rd_status && i_status_read_clear_en);

endmodule : cpd_clock_prescale_and_drive_gate

// *** cpd_pkg.sv ***
// Purpose: Constants and helpers for the clock prescalers and driver enable gate
// Assumes: One system clock; register access by address/strobe port
// Notes:   Every offset and field position, and the status, divider and synchroniser reset values, live here
//
// How it works
// R1: Software writes both divider ratio registers
// R2: Core clock divides system clock by field+1
// R3: Registers run on undivided system clock
// R4: Field value gates single, dual core, flags
// R5: Offset clock divides by 8-bit field+1
// R6: Separate high-side and low-side enable outputs
// R7: Low-side 1-6 need gate, pin, no undervoltage
// R8: Low-side 7 may ignore the pin
// R9: High-side adds optional boost undervoltage cut
// R10: Seven-bit status latches every disabling condition
// R11: Clock-lost bit set only when cut enabled
// R12: Pin-not-low bit falls once pin seen low
// R13: Live copy of the drive-enable pin level
// R14: Overtemperature latched but never disables drivers
// R15: Boost bit set only when boost cut enabled
// R16: Logic bit own; predrive bit includes ground loss
// R17: Status write clears bits whose cause gone
// R18: Status read clears too when enabled
// R19: Clock missing forces gate low when enabled
// R20: Bypass bit makes low-side 7 ignore pin
// R21: Enables and latching evaluated on system clock

package cpd_pkg;

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  localparam int unsigned CPD_ADDR_W          = 10;
  localparam int unsigned CPD_DATA_W          = 16;
  localparam logic [9:0]  CPD_CORE_DIV_ADDR   = 10'h1C0;
  localparam logic [9:0]  CPD_OFS_DIV_ADDR    = 10'h1C4;
  localparam logic [9:0]  CPD_STATUS_ADDR     = 10'h1D2;

  // ---------------------------------------------------------------
  // Divider fields
  // ---------------------------------------------------------------
  localparam int unsigned CPD_CORE_DIV_W      = 6;
  localparam int unsigned CPD_OFS_DIV_W       = 8;
  localparam logic [5:0]  CPD_CORE_DIV_RESET  = 6'h00;
  localparam logic [7:0]  CPD_OFS_DIV_RESET   = 8'h00;
  localparam logic [5:0]  CPD_SINGLE_CORE_MIN = 6'h01;
  localparam logic [5:0]  CPD_DUAL_CORE_MIN   = 6'h03;

  // ---------------------------------------------------------------
  // Status layout
  // ---------------------------------------------------------------
  localparam int unsigned CPD_STATUS_W        = 7;
  localparam int unsigned CPD_ST_PREDRIVE     = 0;
  localparam int unsigned CPD_ST_LOGIC        = 1;
  localparam int unsigned CPD_ST_BOOST        = 2;
  localparam int unsigned CPD_ST_OVER_TEMP    = 3;
  localparam int unsigned CPD_ST_PIN_LEVEL    = 4;
  localparam int unsigned CPD_ST_PIN_NOT_LOW  = 5;
  localparam int unsigned CPD_ST_CLOCK_LOST   = 6;
  localparam logic [6:0]  CPD_STATUS_RESET    = 7'h20;

  // ---------------------------------------------------------------
  // Synchronised input positions
  // ---------------------------------------------------------------
  localparam int unsigned CPD_SYNC_W          = 7;
  localparam int unsigned CPD_IN_PIN          = 0;
  localparam int unsigned CPD_IN_PREDRIVE     = 1;
  localparam int unsigned CPD_IN_LOGIC        = 2;
  localparam int unsigned CPD_IN_BOOST        = 3;
  localparam int unsigned CPD_IN_GND_LOSS     = 4;
  localparam int unsigned CPD_IN_OVER_TEMP    = 5;
  localparam int unsigned CPD_IN_CLK_MISSING  = 6;
  localparam logic [6:0]  CPD_SYNC_RESET      = 7'h00;

  // Sticky bit: set wins, clear only when the cause is gone
  function automatic logic cpd_sticky(input logic cur, input logic set,
                                      input logic clr, input logic present);
    cpd_sticky = set | (cur & ~(clr & ~present));
  endfunction : cpd_sticky

endpackage : cpd_pkg

// *** cpd_clock_divider.sv ***
// Purpose: Programmable divide-by-(ratio+1) clock generator
// Assumes: Ratio comes from a register on the same clock
// Notes:   Ratio zero gives a tick every cycle and a level held high
`timescale 1ns/1ps

module cpd_clock_divider #(
  parameter int unsigned W = 6
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Ratio
  input  wire logic [W-1:0] i_ratio,
  // Divided outputs
  output logic              o_tick,
  output logic              o_clk
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         tick_reg;
  logic         tick_next;
  logic         clk_reg;
  logic         clk_next;

  // Count 0..ratio, wrap early if the ratio shrank
  always_comb begin
    if (count_reg >= i_ratio) begin
      count_next = '0;
    end else begin
      count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
    end
    tick_next = (count_next == '0);
    clk_next  = (count_next <= (i_ratio >> 1));
  end

  // Register divider state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
      clk_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
      clk_reg   <= clk_next;
    end
  end

  assign o_tick = tick_reg;
  assign o_clk  = clk_reg;

endmodule : cpd_clock_divider

// *** cpd_mcu_model.sv ***
// Purpose: Microcontroller model driving the register port
// Assumes: Strobes last one cycle, read answer one cycle later
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ps

module cpd_mcu_model (
  // Clock
  input  wire logic        i_clk,
  // Register port
  output logic             o_wr,
  output logic             o_rd,
  output logic [9:0]       o_addr,
  output logic [15:0]      o_wdata,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  initial begin
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_addr = 10'h0;
    o_wdata = 16'h0;
  end

  // Divider setup and status clear by write
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    @(posedge i_clk);
    #1;
    o_wr = 1'h1;
    o_addr = a;
    o_wdata = v;
    @(posedge i_clk);
    #1;
    o_wr = 1'h0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask : wr

  // Read, answer taken one edge after the strobe
  task automatic rd(input logic [9:0] a, output logic [15:0] v, output logic ok);
    @(posedge i_clk);
    #1;
    o_rd = 1'h1;
    o_addr = a;
    @(posedge i_clk);
    #1;
    o_rd = 1'h0;
    o_addr = ~o_addr;
    v = i_rdata;
    ok = i_rvalid;
  endtask : rd
endmodule : cpd_mcu_model

// *** cpd_clock_prescale_and_drive_gate_bench.sv ***
// Purpose: Self-checking bench for prescalers and driver enable gate
// Assumes: Register port driven by the microcontroller model
// Notes:   Inputs held five cycles so the synchronisers settle
`timescale 1ns/1ps

module cpd_clock_prescale_and_drive_gate_bench;
  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  localparam logic [9:0] CA = cpd_pkg::CPD_CORE_DIV_ADDR;
  localparam logic [9:0] OA = cpd_pkg::CPD_OFS_DIV_ADDR;
  localparam logic [9:0] SA = cpd_pkg::CPD_STATUS_ADDR;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        wr, rd, rv, ls, ls7, hs, ctk, otk, sgl, dual, flg, v, ck, ock;
  logic        cut = 1'h0, byp = 1'h0, bcut = 1'h0, rce = 1'h0, pin = 1'h1;
  logic        pre = 1'h0, lgc = 1'h0, bst = 1'h0, gnd = 1'h0, ot = 1'h0, miss = 1'h0;
  logic [9:0]  addr;
  logic [15:0] wdata, rdata, d;
  logic [6:0]  st;
  int          errors = 0, samples_checked = 0, seed = 20;
  int          cf[6] = '{0, 1, 2, 3, 4, 63};
  int          of[3] = '{0, 8, 255};

  // Clock, 4 ns period
  always #2 clk = ~clk;

  cpd_mcu_model u_cpd_mcu_model (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rv));

  cpd_clock_prescale_and_drive_gate u_cpd_clock_prescale_and_drive_gate (
    .i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rv),
    .i_clk_loss_cut_en(cut), .i_low_side7_pin_bypass(byp), .i_boost_cut_en(bcut),
    .i_status_read_clear_en(rce), .i_drive_enable_pin(pin), .i_predrive_supply_low(pre),
    .i_logic_supply_low(lgc), .i_boost_supply_low(bst), .i_ground_loss(gnd),
    .i_over_temp(ot), .i_clock_missing(miss), .o_low_side_enable(ls),
    .o_low_side7_enable(ls7), .o_high_side_enable(hs), .o_core_clock(ck),
    .o_core_tick(ctk), .o_offset_comp_clock(ock), .o_offset_comp_tick(otk),
    .o_single_core_allowed(sgl), .o_dual_core_allowed(dual), .o_flag_drive_allowed(flg));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  function automatic logic rare();
    rare = ($random(seed) & 3) == 0;
  endfunction : rare

  // Conditions that latch a status bit right now
  function automatic logic [6:0] cause();
    cause = {cut & miss, 2'h0, ot, bcut & bst, lgc, pre | gnd};
  endfunction : cause

  function automatic logic tk(input logic [9:0] a);
    tk = (a == CA) ? ctk : otk;
  endfunction : tk

  // Divided clock level of the divider at this address
  function automatic logic cl(input logic [9:0] a);
    cl = (a == CA) ? ck : ock;
  endfunction : cl

  // Clear keeps bits whose cause remains, re-arms pin bit
  task automatic clr();
    st = (st & cause()) | {1'h0, pin, pin, 4'h0};
  endtask : clr

  // Hold inputs, then accumulate latched conditions
  task automatic hold();
    repeat (5) @(posedge clk);
    #1;
    st = st | cause();
    st[5] = st[5] & pin;
    st[4] = pin;
  endtask : hold

  // Program one divider, check modes, tick period and readback
  task automatic div(input logic [9:0] a, input int f);
    int n;
    int h;
    u_cpd_mcu_model.wr(a, 16'(f) | ((a == CA) ? 16'hFFC0 : 16'hFF00));
    repeat (3) @(posedge clk);
    #1;
    if (a == CA) begin
      chk({sgl, dual, flg}, {f >= 1, f >= 3, f >= 1}, "modes");
    end
    n = 0;
    while (tk(a) !== 1'h1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    h = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      h += int'(cl(a) === 1'h1);
    end while (tk(a) !== 1'h1 && n < 600);
    chk(n[15:0], 16'(f + 1), "tick period");
    chk(h[15:0], 16'(f / 2 + 1), "clock high");
    u_cpd_mcu_model.rd(a, d, v);
    chk({v, d[14:0]}, {1'h1, 15'(f)}, "readback");
  endtask : div

  // Random configuration, then random flags; check enables and status
  task automatic step();
    logic ok;
    @(posedge clk);
    #1;
    {cut, byp, bcut, rce} = 4'($random(seed));
    hold();
    {pre, lgc, bst, gnd, ot, miss} = {rare(), rare(), rare(), rare(), rare(), rare()};
    pin = !rare();
    hold();
    ok = !(cut && miss) && !pre && !gnd && !lgc;
    chk({ls, ls7, hs}, {ok && pin, ok && (pin || byp), ok && pin && !(bcut && bst)},
        "enables");
    u_cpd_mcu_model.rd(SA, d, v);
    chk(d, {9'h0, st}, "status");
    if (rce) clr();
    if (rare()) begin
      u_cpd_mcu_model.wr(SA, 16'($random(seed)));
      clr();
    end
  endtask : step

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    st = 7'h0;
    repeat (20) @(posedge clk);
    #1;
    chk({ls, ls7, hs, sgl, ctk}, 16'h0, "reset");
    rst = 1'h0;
    hold();
    u_cpd_mcu_model.wr(SA, 16'h0);
    clr();
    foreach (cf[i]) div(CA, cf[i]);
    div(CA, $random(seed) & 63);
    foreach (of[i]) div(OA, of[i]);
    div(OA, $random(seed) & 255);
    u_cpd_mcu_model.wr(10'h1C2, 16'hFFFF);
    u_cpd_mcu_model.rd(10'h1C2, d, v);
    chk({v, d[14:0]}, 16'h8000, "unmapped");
    $display("test dividers done");
    repeat (60) step();
    $display("test enables and status done");
    close_out();
  end

  initial begin
    #200000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
endmodule : cpd_clock_prescale_and_drive_gate_bench
